// ### inc/spx_pkg.sv
/*
 * spx_pkg: register map, field positions, reset values, state and carrier
 * types of the serial port with its auxiliary interrupt stage.
 * assumes: byte-wide special function register access on the system clock.
 */
package spx_pkg;

    // ----------------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------------
    localparam logic [7:0] SPX_ADDR_CTRL = 8'h9a;
    localparam logic [7:0] SPX_ADDR_DATA = 8'h9b;
    localparam logic [7:0] SPX_ADDR_DRIVE = 8'h9d;
    localparam logic [7:0] SPX_ADDR_PEND = 8'ha5;
    localparam logic [7:0] SPX_ADDR_AIE = 8'ha6;
    localparam logic [7:0] SPX_ADDR_STAT = 8'ha7;

    // ----------------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------------
    localparam int SPX_DIV_HI = 7;
    localparam int SPX_DIV_LO = 5;
    localparam int SPX_ORDER = 3;
    localparam int SPX_MASTER = 2;
    localparam int SPX_CPHA = 1;
    localparam int SPX_CPOL = 0;
    localparam int SPX_CLK_EN = 5;
    localparam int SPX_DRIVE_DELAY_SELECT = 4;
    localparam int SPX_OUTPUT_DRIVE_ENABLE = 3;
    localparam int SPX_AUX_TX = 3;
    localparam int SPX_AUX_RX = 2;
    localparam logic [7:0] SPX_CTRL_WMASK = 8'hef;
    localparam logic [7:0] SPX_DRIVE_WMASK = 8'h38;
    localparam logic [7:0] SPX_CTRL_RESET = 8'h00;
    localparam logic [7:0] SPX_DRIVE_RESET = 8'h00;
    localparam logic [7:0] SPX_AIE_RESET = 8'h00;
    localparam logic [15:0] SPX_AUX_VECTOR = 16'h0033;

    // ----------------------------------------------------------------------
    // timing: eight bits give sixteen clock edges per byte
    // ----------------------------------------------------------------------
    localparam int SPX_CLK_HZ = 25_000_000;
    localparam logic [3:0] SPX_EDGE_LAST = 4'hf;

    // ----------------------------------------------------------------------
    // types
    // ----------------------------------------------------------------------
    typedef enum logic {SPX_IDLE, SPX_RUN} spx_phase_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } spx_sfr_req_t;

    typedef struct packed {
        spx_phase_t phase;
        logic [7:0] ctrl;
        logic [7:0] drive;
        logic [7:0] aux_interrupt_enable;
        logic [7:0] tx_buf;
        logic tx_full;
        logic [7:0] tsr;
        logic [7:0] rsr;
        logic dout;
        logic sck;
        logic [7:0] div_cnt;
        logic [3:0] edge_cnt;
        logic drv_act;
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
        logic din_s1;
        logic din_s2;
        logic sel_s1;
        logic sel_s2;
        logic [7:0] rdata;
    } spx_state_t;

endpackage : spx_pkg

// ### src/spx_fifo2.sv
/*
 * spx_fifo2: two-entry buffer with valid/ready on both sides and a flush.
 * assumes: both sides on the same clock; flush wins over push and pop.
 */
`timescale 1ns/1ps
module spx_fifo2 #(
    parameter int WIDTH = 8
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] count;
    } spx_fifo_t;

    spx_fifo_t st;
    spx_fifo_t next_st;
    logic push;
    logic pop;

    assign in_ready_out = (st.count != 2'd2);
    assign out_valid_out = (st.count != 2'd0);
    assign out_data_out = st.mem[st.rp];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data_in;
            next_st.wp = ~st.wp;
        end
        if (pop) begin
            next_st.rp = ~st.rp;
        end
        next_st.count = st.count + {1'b0, push} - {1'b0, pop};
        if (flush_in) begin
            next_st.wp = 1'b0;
            next_st.rp = 1'b0;
            next_st.count = 2'd0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : spx_fifo2

// ### src/spx_port.sv
/*
 * spx_port: byte serial port (master or slave) with its registers and the
 * auxiliary interrupt encoder that merges its two events with six others.
 * assumes: a byte register port with one-cycle read and write strobes on
 * the system clock; the other auxiliary sources arrive as same-clock levels.
 */
`timescale 1ns/1ps
module spx_port
    import spx_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire spx_sfr_req_t sfr_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic port_enable_in,
    input wire logic aux_global_enable_in,
    input wire logic [7:0] aux_sources_in,
    output logic aux_irq_out,
    output logic [15:0] aux_vector_out,
    input wire logic select_n_in,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n_out,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n_out,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n_out
);
    spx_state_t st;
    spx_state_t next_st;

    logic master;
    logic cpha;
    logic cpol;
    logic lsb_first;
    logic [7:0] half_m1;
    logic ctrl_change;
    logic flush;
    logic wr_data;
    logic rd_data;
    logic tick;
    logic sample_edge;
    logic shift_edge;
    logic byte_done;
    logic rx_push;
    logic rx_ready;
    logic rx_valid;
    logic [7:0] rx_head;
    logic [7:0] rx_next;
    logic [7:0] raw;
    logic [7:0] masked;
    logic [3:0] pend_code;
    logic drv_target;

    // ----------------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------------
    assign master = st.ctrl[SPX_MASTER];
    assign cpha = st.ctrl[SPX_CPHA];
    assign cpol = st.ctrl[SPX_CPOL];
    assign lsb_first = st.ctrl[SPX_ORDER];
    // half period is 2^code system clocks, so a full period is clk/2..clk/256
    assign half_m1 = (8'h01 << st.ctrl[SPX_DIV_HI:SPX_DIV_LO]) - 8'h01;
    assign wr_data = sfr_in.wr && (sfr_in.addr == SPX_ADDR_DATA);
    assign rd_data = sfr_in.rd && (sfr_in.addr == SPX_ADDR_DATA);
    assign ctrl_change = sfr_in.wr && (sfr_in.addr == SPX_ADDR_CTRL)
        && ((sfr_in.wdata & SPX_CTRL_WMASK) != st.ctrl);
    assign flush = ctrl_change || !port_enable_in;

    // ----------------------------------------------------------------------
    // bit engine events
    // ----------------------------------------------------------------------
    // slave edges come from the synchronised clock, so the slave clock must
    // stay below about a sixth of the system clock
    always_comb begin
        tick = 1'b0;
        if (st.phase == SPX_RUN) begin
            if (master) begin
                tick = (st.div_cnt == half_m1);
            end else begin
                tick = (st.sck_s2 != st.sck_s3);
            end
        end
    end

    assign sample_edge = tick && (st.edge_cnt[0] == cpha);
    assign shift_edge = tick && (cpha ? !st.edge_cnt[0] : (st.edge_cnt[0] && st.edge_cnt != SPX_EDGE_LAST));
    assign byte_done = tick && (st.edge_cnt == SPX_EDGE_LAST);
    assign rx_push = byte_done && !flush;
    // the last edge samples only in phase 1; in phase 0 the byte is already whole
    assign rx_next = lsb_first ? {st.din_s2, st.rsr[7:1]} : {st.rsr[6:0], st.din_s2};

    // ----------------------------------------------------------------------
    // receive buffer
    // ----------------------------------------------------------------------
    // a slave cannot stall its master: a third unread byte is dropped there
    spx_fifo2 #(
        .WIDTH(8)
    ) rx_buf (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .flush_in(flush),
        .in_valid_in(rx_push),
        .in_data_in(sample_edge ? rx_next : st.rsr),
        .in_ready_out(rx_ready),
        .out_valid_out(rx_valid),
        .out_data_out(rx_head),
        .out_ready_in(rd_data)
    );

    // ----------------------------------------------------------------------
    // auxiliary interrupts
    // ----------------------------------------------------------------------
    always_comb begin
        raw = aux_sources_in;
        raw[SPX_AUX_RX] = rx_valid;
        raw[SPX_AUX_TX] = !st.tx_full && port_enable_in;
    end

    assign masked = raw & st.aux_interrupt_enable;

    always_comb begin
        pend_code = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (masked[i]) begin
                pend_code = 4'(i + 1);
            end
        end
    end

    assign aux_irq_out = aux_global_enable_in && (masked != 8'h00);
    assign aux_vector_out = SPX_AUX_VECTOR;

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.sck_s1 = sck_in;
        next_st.sck_s2 = st.sck_s1;
        next_st.sck_s3 = st.sck_s2;
        next_st.din_s1 = master ? miso_in : mosi_in;
        next_st.din_s2 = st.din_s1;
        next_st.sel_s1 = select_n_in;
        next_st.sel_s2 = st.sel_s1;
        drv_target = st.drive[SPX_OUTPUT_DRIVE_ENABLE];

        // register writes
        if (sfr_in.wr) begin
            case (sfr_in.addr)
                SPX_ADDR_CTRL: next_st.ctrl = sfr_in.wdata & SPX_CTRL_WMASK;
                SPX_ADDR_DRIVE: next_st.drive = sfr_in.wdata & SPX_DRIVE_WMASK;
                SPX_ADDR_AIE: next_st.aux_interrupt_enable = sfr_in.wdata;
                default: begin
                end
            endcase
        end

        // register reads are answered one cycle after the strobe
        if (sfr_in.rd) begin
            case (sfr_in.addr)
                SPX_ADDR_CTRL: next_st.rdata = st.ctrl;
                SPX_ADDR_DATA: next_st.rdata = rx_head;
                SPX_ADDR_DRIVE: next_st.rdata = st.drive;
                SPX_ADDR_PEND: next_st.rdata = {4'h0, pend_code};
                SPX_ADDR_AIE: next_st.rdata = raw;
                SPX_ADDR_STAT: next_st.rdata = masked;
                default: next_st.rdata = 8'h00;
            endcase
        end

        // bit engine
        case (st.phase)
            SPX_IDLE: begin
                next_st.sck = cpol;
                next_st.div_cnt = 8'h00;
                next_st.edge_cnt = 4'h0;
                if (port_enable_in && ((master && st.tx_full && rx_ready) || (!master && !st.sel_s2))) begin
                    next_st.phase = SPX_RUN;
                    next_st.tsr = st.tx_full ? st.tx_buf : 8'h00;
                    next_st.tx_full = 1'b0;
                    if (!cpha) begin
                        // first bit stands half a period before the first edge
                        next_st.dout = next_st.tsr[lsb_first ? 0 : 7];
                        next_st.tsr = lsb_first ? {1'b0, next_st.tsr[7:1]} : {next_st.tsr[6:0], 1'b0};
                    end
                end
            end
            SPX_RUN: begin
                next_st.div_cnt = tick ? 8'h00 : st.div_cnt + 8'h01;
                if (tick) begin
                    next_st.edge_cnt = st.edge_cnt + 4'h1;
                    if (master) begin
                        next_st.sck = ~st.sck;
                    end
                end
                if (sample_edge) begin
                    next_st.rsr = rx_next;
                end
                if (shift_edge) begin
                    next_st.dout = st.tsr[lsb_first ? 0 : 7];
                    next_st.tsr = lsb_first ? {1'b0, st.tsr[7:1]} : {st.tsr[6:0], 1'b0};
                end
                if (byte_done) begin
                    next_st.phase = SPX_IDLE;
                    next_st.drv_act = drv_target;
                end
                if (!master && st.sel_s2) begin
                    next_st.phase = SPX_IDLE;
                end
            end
            default: next_st.phase = SPX_IDLE;
        endcase

        // a write after the engine took the old byte refills the buffer
        if (wr_data) begin
            next_st.tx_buf = sfr_in.wdata;
            next_st.tx_full = 1'b1;
        end

        // delayed drive changes wait for the byte in flight only
        if (!st.drive[SPX_DRIVE_DELAY_SELECT] || st.phase == SPX_IDLE) begin
            next_st.drv_act = drv_target;
        end

        if (flush) begin
            next_st.phase = SPX_IDLE;
            next_st.tx_full = 1'b0;
            next_st.edge_cnt = 4'h0;
            next_st.div_cnt = 8'h00;
            next_st.rsr = 8'h00;
            next_st.tsr = 8'h00;
            next_st.sck = ctrl_change ? sfr_in.wdata[SPX_CPOL] : cpol;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------------
    assign sfr_rdata_out = st.rdata;
    assign sck_out = st.sck;
    assign sck_oe_n_out = !(master && st.drive[SPX_CLK_EN] && port_enable_in);
    assign mosi_out = st.dout;
    assign miso_out = st.dout;
    assign mosi_oe_n_out = !(master && st.drv_act && port_enable_in);
    assign miso_oe_n_out = !(!master && st.drv_act && port_enable_in);

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    a_ctrl_change_resets: assert property (ctrl_change |=> st.phase == SPX_IDLE && st.edge_cnt == 4'h0
        && !st.tx_full)
        else $error("control change did not reset the engine");
    a_disabled_stays_idle: assert property (!port_enable_in
        |-> sck_oe_n_out && mosi_oe_n_out && miso_oe_n_out ##1 st.phase == SPX_IDLE)
        else $error("port ran while disabled");
    a_idle_clock_level: assert property (st.phase == SPX_IDLE && $stable(st.ctrl) && $past(st.phase) == SPX_IDLE
        |-> sck_out == cpol)
        else $error("idle clock not at polarity level");
    a_master_half_period: assert property (st.phase == SPX_RUN && master && tick && !flush
        ##1 st.phase == SPX_RUN |-> st.div_cnt == 8'h00 && (tick == (half_m1 == 8'h00)))
        else $error("divider count wrong after edge");
    a_write_sets_tx: assert property (wr_data && !flush |=> st.tx_full && !raw[SPX_AUX_TX])
        else $error("data write left transmit interrupt set");
    a_read_pops_rx: assert property (rd_data && rx_valid |=> sfr_rdata_out == $past(rx_head))
        else $error("data read returned wrong byte");
    a_aie_reads_raw: assert property (sfr_in.rd && sfr_in.addr == SPX_ADDR_AIE |=> sfr_rdata_out == $past(raw))
        else $error("enable read did not return raw sources");
    a_top_priority: assert property (masked[0] |-> pend_code == 4'h1 && (aux_irq_out == aux_global_enable_in))
        else $error("highest source not encoded first");
    a_none_pending: assert property ((masked == 8'h00) |-> pend_code == 4'h0 && !aux_irq_out)
        else $error("code nonzero with nothing pending");
    a_sck_driver_off: assert property (!st.drive[SPX_CLK_EN] |-> sck_oe_n_out)
        else $error("clock driven while driver disabled");
    a_byte_push: assert property (byte_done && !flush |-> rx_push ##1 rx_valid)
        else $error("completed byte not buffered");
    a_drive_now: assert property (!st.drive[SPX_DRIVE_DELAY_SELECT] |=> st.drv_act == $past(st.drive[SPX_OUTPUT_DRIVE_ENABLE]))
        else $error("immediate drive change not applied");
    a_drive_held: assert property (st.drive[SPX_DRIVE_DELAY_SELECT] && st.phase == SPX_RUN && !byte_done
        |=> $stable(st.drv_act))
        else $error("delayed drive change applied mid byte");

    c_master_byte: cover property (master && byte_done);
    c_slave_byte: cover property (!master && byte_done);
    c_rx_full: cover property (!rx_ready && rd_data);
    c_aux_irq: cover property (aux_irq_out && pend_code == 4'h4);
endmodule : spx_port

// ### test/spx_slave_model.sv
/*
 * spx_slave_model: far-end serial device answering the port in master mode.
 * assumes: load pulses while the serial clock rests at its idle level.
 */
`timescale 1ns/1ps
module spx_slave_model (
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic cpol_in,
    input wire logic cpha_in,
    input wire logic lsb_in,
    input wire logic load_in,
    input wire logic [7:0] tx_byte_in,
    output logic miso_out,
    output logic [7:0] rx_byte_out
);
    logic [7:0] tsr = 8'h00;
    int n = 0;
    initial miso_out = 1'b0;
    initial rx_byte_out = 8'h00;
    function automatic logic head(input logic [7:0] v, input logic ls);
        return ls ? v[0] : v[7];
    endfunction : head
    // released line shows the inverse so a stale bit is never mistaken for data
    always @(posedge load_in) begin
        tsr = tx_byte_in;
        n = 0;
        miso_out = cpha_in ? ~miso_out : head(tx_byte_in, lsb_in);
    end
    always @(sck_in) begin
        if ((sck_in !== cpol_in) != cpha_in) begin
            rx_byte_out = lsb_in ? {mosi_in, rx_byte_out[7:1]} : {rx_byte_out[6:0], mosi_in};
            n++;
            if (cpha_in && n == 8) begin
                miso_out = ~miso_out;
            end
        end else if (cpha_in) begin
            miso_out = head(tsr, lsb_in);
            tsr = lsb_in ? tsr >> 1 : tsr << 1;
        end else begin
            tsr = lsb_in ? tsr >> 1 : tsr << 1;
            miso_out = (n < 8) ? head(tsr, lsb_in) : ~miso_out;
        end
    end
endmodule : spx_slave_model

// ### test/tb_spx_port.sv
/*
 * tb_spx_port: self-checking bench for the serial port and aux interrupts.
 * assumes: spx_pkg and the design compiled first; slave model on the link.
 */
`timescale 1ns/1ps
`define CHK(g, e) check_eq(16'(g), 16'(e))
module tb_spx_port;
    import spx_pkg::*;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic port_en = 1'b0, glob_en = 1'b0, sel_n = 1'b1, load = 1'b0;
    logic cpol = 1'b0, cpha = 1'b0, lsb = 1'b0, sck_drv = 1'b0, mosi_drv = 1'b1;
    spx_sfr_req_t sfr = '0;
    logic [7:0] rdata = 8'h00, srcs = 8'h00, s_tx = 8'h00, s_rx, sfr_rd;
    logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, miso_m, irq;
    logic [15:0] vec;
    int n_fail = 0;
    int comparisons = 0;
    // released lines follow the bench's own master: clock idle low, data idle high
    wire sck_w = sck_oe_n ? sck_drv : sck_o;
    wire mosi_w = mosi_oe_n ? mosi_drv : mosi_o;
    always #20 clock_in = ~clock_in;
    spx_port dut_u (.clock_in(clock_in), .reset_in(reset_in), .sfr_in(sfr), .sfr_rdata_out(sfr_rd),
        .port_enable_in(port_en), .aux_global_enable_in(glob_en), .aux_sources_in(srcs),
        .aux_irq_out(irq), .aux_vector_out(vec), .select_n_in(sel_n), .sck_in(sck_w),
        .sck_out(sck_o), .sck_oe_n_out(sck_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_o),
        .mosi_oe_n_out(mosi_oe_n), .miso_in(miso_m), .miso_out(miso_o), .miso_oe_n_out(miso_oe_n));
    spx_slave_model far_u (.sck_in(sck_w), .mosi_in(mosi_w), .cpol_in(cpol), .cpha_in(cpha),
        .lsb_in(lsb), .load_in(load), .tx_byte_in(s_tx), .miso_out(miso_m), .rx_byte_out(s_rx));
    // ----------------------------------------------------------------------
    // helpers: every task starts and ends 1 ns after a rising edge
    // ----------------------------------------------------------------------
    task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_eq
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        cyc(1);
        sfr = '0;
        cyc(1);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        cyc(1);
        sfr = '0;
        cyc(1);
        rdata = sfr_rd;
    endtask : rd
    task automatic pulse(input logic [7:0] v);
        s_tx = v;
        load = 1'b1;
        cyc(1);
        load = 1'b0;
    endtask : pulse
    task automatic wait_rx();
        int k;
        k = 0;
        rdata = 8'h00;
        while (rdata[SPX_AUX_RX] !== 1'b1 && k < 3000) begin
            rd(SPX_ADDR_AIE);
            k++;
        end
        `CHK(rdata[SPX_AUX_RX], 1'b1);
    endtask : wait_rx
    task automatic wrap_up();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // ----------------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] regs [7] = '{8'h9a, 8'h9b, 8'h9d, 8'ha5, 8'ha6, 8'ha7, 8'h9c};
        `CHK({sck_oe_n, mosi_oe_n, miso_oe_n, irq}, 4'he);
        `CHK(vec, 16'h0033);
        for (int i = 0; i < 7; i++) begin
            rd(regs[i]);
            `CHK(rdata, 8'h00);
        end
        wr(SPX_ADDR_CTRL, 8'hff);
        rd(SPX_ADDR_CTRL);
        `CHK(rdata, 8'hef);
        wr(SPX_ADDR_DRIVE, 8'hff);
        rd(SPX_ADDR_DRIVE);
        `CHK(rdata, 8'h38);
        wr(SPX_ADDR_PEND, 8'hff);
        rd(SPX_ADDR_PEND);
        `CHK(rdata, 8'h00);
        wr(SPX_ADDR_CTRL, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_disable();
        int c;
        c = 0;
        wr(SPX_ADDR_DRIVE, 8'h28);
        wr(SPX_ADDR_CTRL, 8'h24);
        wr(SPX_ADDR_DATA, 8'h66);
        for (int i = 0; i < 100; i++) begin
            cyc(1);
            c += sck_w;
        end
        `CHK(c, 0);
        rd(SPX_ADDR_AIE);
        `CHK(rdata, 8'h00);
        port_en = 1'b1;
        wr(SPX_ADDR_CTRL, 8'h00);
        $display("test disable done");
    endtask : t_disable
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            {lsb, cpha, cpol} = 3'(m);
            wr(SPX_ADDR_CTRL, {3'h2, 1'b0, lsb, 1'b1, cpha, cpol});
            cyc(2);
            pulse(8'hc8 | 8'(m));
            wr(SPX_ADDR_DATA, 8'h17 ^ 8'(m));
            wait_rx();
            `CHK(sck_w, cpol);
            rd(SPX_ADDR_DATA);
            `CHK(rdata, 8'hc8 | 8'(m));
            `CHK(s_rx, 8'h17 ^ 8'(m));
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_divider();
        int c;
        {lsb, cpha, cpol} = 3'h0;
        for (int d = 0; d < 8; d++) begin
            wr(SPX_ADDR_CTRL, {3'(d), 5'h04});
            wr(SPX_ADDR_DATA, 8'h5a);
            c = 0;
            while (sck_w === 1'b0 && c < 600) begin
                cyc(1);
                c++;
            end
            c = 0;
            while (sck_w === 1'b1 && c < 600) begin
                cyc(1);
                c++;
            end
            `CHK(c, 1 << d);
            wait_rx();
            rd(SPX_ADDR_DATA);
        end
        $display("test divider done");
    endtask : t_divider
    task automatic t_drive();
        wr(SPX_ADDR_CTRL, 8'h64);
        wr(SPX_ADDR_DRIVE, 8'h28);
        `CHK({sck_oe_n, mosi_oe_n, miso_oe_n}, 3'h1);
        wr(SPX_ADDR_DRIVE, 8'h20);
        `CHK(mosi_oe_n, 1'b1);
        wr(SPX_ADDR_DRIVE, 8'h08);
        `CHK(sck_oe_n, 1'b1);
        wr(SPX_ADDR_CTRL, 8'h60);
        `CHK({sck_oe_n, mosi_oe_n, miso_oe_n}, 3'h6);
        wr(SPX_ADDR_CTRL, 8'h64);
        wr(SPX_ADDR_DRIVE, 8'h28);
        pulse(8'h00);
        wr(SPX_ADDR_DATA, 8'h99);
        cyc(20);
        wr(SPX_ADDR_DRIVE, 8'h30);
        `CHK(mosi_oe_n, 1'b0);
        wait_rx();
        `CHK(mosi_oe_n, 1'b1);
        rd(SPX_ADDR_DATA);
        wr(SPX_ADDR_DRIVE, 8'h28);
        $display("test drive done");
    endtask : t_drive
    task automatic t_abort();
        wr(SPX_ADDR_CTRL, 8'he4);
        wr(SPX_ADDR_DATA, 8'h3c);
        cyc(300);
        wr(SPX_ADDR_CTRL, 8'hc4);
        cyc(2200);
        rd(SPX_ADDR_AIE);
        `CHK(rdata, 8'h08);
        `CHK(sck_w, 1'b0);
        $display("test abort done");
    endtask : t_abort
    task automatic t_buffer();
        logic [7:0] b [3] = '{8'h81, 8'h42, 8'h24};
        wr(SPX_ADDR_CTRL, 8'h44);
        for (int i = 0; i < 3; i++) begin
            pulse(b[i]);
            wr(SPX_ADDR_DATA, 8'h10 + 8'(i));
            cyc(80);
        end
        rd(SPX_ADDR_AIE);
        `CHK(rdata, 8'h04);
        rd(SPX_ADDR_DATA);
        `CHK(rdata, b[0]);
        rd(SPX_ADDR_DATA);
        `CHK(rdata, b[1]);
        wait_rx();
        rd(SPX_ADDR_DATA);
        `CHK(rdata, b[2]);
        `CHK(s_rx, 8'h12);
        $display("test buffer done");
    endtask : t_buffer
    task automatic t_irq();
        wr(SPX_ADDR_CTRL, 8'h00);
        wr(SPX_ADDR_AIE, 8'h0c);
        `CHK(irq, 1'b0);
        glob_en = 1'b1;
        cyc(1);
        `CHK(irq, 1'b1);
        rd(SPX_ADDR_PEND);
        `CHK(rdata, 8'h04);
        rd(SPX_ADDR_STAT);
        `CHK(rdata, 8'h08);
        wr(SPX_ADDR_AIE, 8'h04);
        `CHK(irq, 1'b0);
        rd(SPX_ADDR_AIE);
        `CHK(rdata, 8'h08);
        wr(SPX_ADDR_DATA, 8'h77);
        rd(SPX_ADDR_AIE);
        `CHK(rdata, 8'h00);
        wr(SPX_ADDR_AIE, 8'hff);
        for (int i = 0; i < 8; i++) begin
            if (i != SPX_AUX_RX && i != SPX_AUX_TX) begin
                srcs = 8'h01 << i;
                rd(SPX_ADDR_PEND);
                `CHK(rdata, i + 1);
                rd(SPX_ADDR_AIE);
                `CHK(rdata, srcs);
            end
        end
        srcs = 8'hf3;
        rd(SPX_ADDR_PEND);
        `CHK(rdata, 8'h01);
        srcs = 8'h00;
        wr(SPX_ADDR_CTRL, 8'h24);
        wr(SPX_ADDR_DATA, 8'h5e);
        wait_rx();
        wr(SPX_ADDR_AIE, 8'h04);
        rd(SPX_ADDR_PEND);
        `CHK(rdata, 8'h03);
        rd(SPX_ADDR_STAT);
        `CHK(rdata, 8'h04);
        rd(SPX_ADDR_DATA);
        rd(SPX_ADDR_AIE);
        `CHK(rdata[SPX_AUX_RX], 1'b0);
        `CHK(irq, 1'b0);
        $display("test irq done");
    endtask : t_irq
    task automatic t_slave();
        logic [7:0] pat = 8'h3c;
        logic [7:0] got = 8'h00;
        wr(SPX_ADDR_CTRL, 8'h00);
        wr(SPX_ADDR_DATA, 8'ha5);
        sel_n = 1'b0;
        cyc(8);
        `CHK(miso_oe_n, 1'b0);
        for (int i = 0; i < 8; i++) begin
            mosi_drv = pat[7 - i];
            cyc(8);
            got = {got[6:0], miso_o};
            sck_drv = 1'b1;
            cyc(8);
            sck_drv = 1'b0;
        end
        cyc(8);
        sel_n = 1'b1;
        mosi_drv = 1'b1;
        `CHK(got, 8'ha5);
        rd(SPX_ADDR_DATA);
        `CHK(rdata, pat);
        $display("test slave done");
    endtask : t_slave
    initial begin
        repeat (10) @(posedge clock_in);
        #1;
        reset_in = 1'b0;
        t_reset();
        t_disable();
        t_modes();
        t_divider();
        t_drive();
        t_abort();
        t_buffer();
        t_irq();
        t_slave();
        wrap_up();
    end
    // watchdog: the whole run needs well under 40000 cycles
    initial begin
        #(40 * 80000);
        n_fail++;
        wrap_up();
    end
endmodule : tb_spx_port
